// ==== core/ssr_pkg.sv ====
// Constants, register map and carrier types for the status and service request unit
// Functional notes
// R1 - Enabled STB bits 2,3,4,5,7 raise SRQ
// R2 - Each STB bit summarises a subordinate source
// R3 - Controller should set all enable bits
// R4 - ESE bit 0 is operation complete
// R5 - STB bit 5 is event summary
// R6 - Serial poll returns the status byte
// R7 - Parallel poll drives exactly one line
// R8 - PPE AND STB, ORed, optionally inverted
// R9 - Individual status readable without parallel poll
// R10 - Poll configure stores line and sense
// R11 - Query returns register bit pattern value
// R12 - STB, ESR 8 bits; SCPI 16 bits
// R13 - Value is sum of bit weights
// R14 - Error queue push, pop one, empty 0
// R15 - Events cleared by CLS and PSC power-on
// R16 - Preset clears SCPI enables, others ones
// R17 - Preset sets PTR ones, clears NTR
// R18 - Device clear flushes buffers, keeps status
// R19 - Only reset changes functional settings
// R20 - Armed output buffer cleared after terminator
// R21 - Bit 15 of SCPI registers is zero
// R22 - SRQ withdrawn when no enabled summary
// R23 - SRE, ESE, PPE cleared only by PSC power-on
package ssr_pkg;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CFG  = 8'h04;
    localparam logic [7:0] A_STB  = 8'h08;
    localparam logic [7:0] A_ESR  = 8'h0C;
    localparam logic [7:0] A_ESE  = 8'h10;
    localparam logic [7:0] A_SRE  = 8'h14;
    localparam logic [7:0] A_PPE  = 8'h18;
    localparam logic [7:0] A_PPC  = 8'h1C;
    localparam logic [7:0] A_IST  = 8'h20;
    localparam logic [7:0] A_QUES = 8'h24;
    localparam logic [7:0] A_OPER = 8'h38;
    localparam logic [7:0] A_ERRQ = 8'h4C;
    localparam logic [7:0] A_SET  = 8'h50;
    localparam logic [7:0] A_ECNT = 8'h54;
    // Offsets inside one SCPI register group
    localparam logic [7:0] R_COND = 8'h00;
    localparam logic [7:0] R_EVT  = 8'h04;
    localparam logic [7:0] R_ENA  = 8'h08;
    localparam logic [7:0] R_PTR  = 8'h0C;
    localparam logic [7:0] R_NTR  = 8'h10;
    // Command bits of the control register
    localparam int C_CLS  = 0;
    localparam int C_SPRE = 1;
    localparam int C_RST  = 2;
    localparam int C_DCL  = 3;
    localparam int C_PMT  = 4;
    localparam int C_PON  = 5;
    // Status byte and event status bit positions, then masks and reset values
    localparam int B_ERR  = 2;
    localparam int B_QUES = 3;
    localparam int B_MAV  = 4;
    localparam int B_ESB  = 5;
    localparam int B_MSS  = 6;
    localparam int B_OPER = 7;
    localparam int E_OPC  = 0;
    localparam logic [15:0] SCPI_MASK = 16'h7FFF;
    localparam logic [15:0] PTR_RST   = 16'h7FFF;
    localparam logic [15:0] SET_RST   = 16'h0000;
    localparam logic [7:0]  SRE_MASK  = 8'hBF;
    localparam logic [2:0]  ERRQ_DEPTH = 3'h7;
    localparam logic        PSC_RST   = 1'b1;

    typedef struct packed {
        logic        opc;
        logic [7:0]  esr_set;
        logic        err_push;
        logic [15:0] err_code;
        logic        obuf_load;
        logic        obuf_drain;
    } ssr_evt_s;

    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe;
    } ssr_pp_s;
endpackage

// ==== core/ssr_unit.sv ====
// Status byte, service request, polls, error queue and reset matrix behind APB
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ssr_unit (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire ssr_pkg::ssr_evt_s evt,
    input  wire logic [15:0]      ques_cond_in,
    input  wire logic [15:0]      oper_cond_in,
    input  wire logic             spoll_req,
    input  wire logic             ppoll_req,
    output logic                  srq,
    output logic                  spoll_valid,
    output logic [7:0]            spoll_byte,
    output ssr_pkg::ssr_pp_s      pp,
    output logic                  obuf_clear,
    output logic                  cmd_flush,
    output logic [15:0]           settings
);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    logic        setup;
    logic        wr;
    logic        rd;
    logic [5:0]  cmd;
    logic        por_pend;
    logic        psc;
    logic        power_on;
    logic        psc_clr;
    logic        cls_all;
    logic        preset;
    logic        dev_clr;
    logic [7:0]  esr;
    logic [7:0]  ese;
    logic [7:0]  sre;
    logic [7:0]  ppe;
    logic [2:0]  ppc_line;
    logic        ppc_sense;
    logic        ppc_en;
    logic        mav;
    logic        armed;
    logic        obuf_clr;
    logic [7:0]  stb_low;
    logic [7:0]  stb_full;
    logic        ist;
    logic [15:0] cond_q [2];
    logic [15:0] ev     [2];
    logic [15:0] ena    [2];
    logic [15:0] ptr    [2];
    logic [15:0] ntr    [2];
    logic [1:0]  sum;
    logic [15:0] errq   [8];
    logic [2:0]  wptr;
    logic [2:0]  rptr;
    logic [3:0]  ecnt;
    logic        pop;
    logic        push;
    logic        errq_clr;
    logic [31:0] next_rdata;
    logic        mapped;
    logic [7:0]  esr_rdclr;

    assign setup = psel & ~penable;
    assign wr    = psel & penable & pready & pwrite;
    assign rd    = psel & penable & pready & ~pwrite;
    assign cmd   = (wr && hit(paddr, ssr_pkg::A_CTRL)) ? pwdata[5:0] : 6'h00;

    // Power-on event fires once after reset release, using the stored PSC flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            por_pend <= 1'b1;
        else
            por_pend <= 1'b0;
    end

    assign power_on = por_pend | cmd[ssr_pkg::C_PON];
    assign psc_clr  = power_on & psc;
    assign cls_all  = cmd[ssr_pkg::C_CLS] | psc_clr;             // [R15]
    assign preset   = cmd[ssr_pkg::C_SPRE] | psc_clr;            // [R16] [R17]
    assign dev_clr  = cmd[ssr_pkg::C_DCL] | power_on;            // [R18]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            psc <= ssr_pkg::PSC_RST;
        else if (wr && hit(paddr, ssr_pkg::A_CFG))
            psc <= pwdata[0];
    end

    // Enable masks survive everything except a PSC power-on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ese <= 8'h00;
            sre <= 8'h00;
            ppe <= 8'h00;
        end
        else if (psc_clr)
        begin
            ese <= 8'h00;                                        // [R23]
            sre <= 8'h00;
            ppe <= 8'h00;
        end
        else if (wr)
        begin
            if (hit(paddr, ssr_pkg::A_ESE))
                ese <= pwdata[7:0];                              // [R4]
            if (hit(paddr, ssr_pkg::A_SRE))
                sre <= pwdata[7:0] & ssr_pkg::SRE_MASK;
            if (hit(paddr, ssr_pkg::A_PPE))
                ppe <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ppc_line  <= 3'h0;
            ppc_sense <= 1'b0;
            ppc_en    <= 1'b0;
        end
        else if (wr && hit(paddr, ssr_pkg::A_PPC))
        begin
            ppc_line  <= pwdata[2:0];                            // [R10]
            ppc_sense <= pwdata[3];
            ppc_en    <= pwdata[4];
        end
    end

    // Functional settings: device clear and status commands leave them alone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            settings <= ssr_pkg::SET_RST;
        else if (cmd[ssr_pkg::C_RST])
            settings <= ssr_pkg::SET_RST;                        // [R19]
        else if (wr && hit(paddr, ssr_pkg::A_SET))
            settings <= pwdata[15:0];
    end

    // Clear-on-read drops only the bits returned, so a later event survives
    assign esr_rdclr = (rd && hit(paddr, ssr_pkg::A_ESR)) ? prdata[7:0] : 8'h00;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            esr <= 8'h00;
        else
            esr <= ((cls_all ? 8'h00 : esr & ~esr_rdclr) | evt.esr_set)
                   | {7'h00, evt.opc};                           // [R4] [R15]
    end

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_scpi
            localparam logic [7:0] BASE = (g == 0) ? ssr_pkg::A_QUES : ssr_pkg::A_OPER;
            logic [15:0] cin;
            logic [15:0] tset;
            logic [15:0] rdclr;
            assign cin   = ((g == 0) ? ques_cond_in : oper_cond_in) & ssr_pkg::SCPI_MASK; // [R21]
            assign tset  = ((cin & ~cond_q[g] & ptr[g]) | (~cin & cond_q[g] & ntr[g])) & ssr_pkg::SCPI_MASK;
            assign rdclr = (rd && hit(paddr, BASE + ssr_pkg::R_EVT)) ? prdata[15:0] : 16'h0000;
            assign sum[g] = |(ev[g] & ena[g]);

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    cond_q[g] <= 16'h0000;
                    ev[g]     <= 16'h0000;
                end
                else
                begin
                    cond_q[g] <= cin;
                    ev[g]     <= (cls_all ? 16'h0000 : ev[g] & ~rdclr) | tset; // [R15]
                end
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    ena[g] <= 16'h0000;
                    ptr[g] <= ssr_pkg::PTR_RST;
                    ntr[g] <= 16'h0000;
                end
                else if (preset)
                begin
                    ena[g] <= 16'h0000;                          // [R16]
                    ptr[g] <= ssr_pkg::PTR_RST;                  // [R17]
                    ntr[g] <= 16'h0000;
                end
                else if (wr)
                begin
                    if (hit(paddr, BASE + ssr_pkg::R_ENA))
                        ena[g] <= pwdata[15:0] & ssr_pkg::SCPI_MASK;
                    if (hit(paddr, BASE + ssr_pkg::R_PTR))
                        ptr[g] <= pwdata[15:0] & ssr_pkg::SCPI_MASK;
                    if (hit(paddr, BASE + ssr_pkg::R_NTR))
                        ntr[g] <= pwdata[15:0] & ssr_pkg::SCPI_MASK;
                end
            end
        end
    endgenerate

    // Error queue: full queue drops new entries rather than old causes
    assign errq_clr = cmd[ssr_pkg::C_CLS] | power_on;
    assign pop  = rd && hit(paddr, ssr_pkg::A_ERRQ) && (ecnt != 4'h0); // [R14]
    assign push = evt.err_push && ((ecnt <= {1'b0, ssr_pkg::ERRQ_DEPTH}) || pop);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wptr <= 3'h0;
            rptr <= 3'h0;
            ecnt <= 4'h0;
        end
        else if (errq_clr)
        begin
            wptr <= 3'h0;
            rptr <= 3'h0;
            ecnt <= 4'h0;
        end
        else
        begin
            wptr <= push ? wptr + 3'h1 : wptr;
            rptr <= pop ? rptr + 3'h1 : rptr;
            ecnt <= ecnt + {3'h0, push} - {3'h0, pop};           // [R14]
        end
    end

    always_ff @(posedge pclk)
    begin
        if (push && !errq_clr)
            errq[wptr] <= evt.err_code;
    end

    // Output buffer state and deferred clear after a terminator
    assign obuf_clr = dev_clr | (armed & cmd[ssr_pkg::C_PMT]);   // [R18] [R20]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            armed <= 1'b0;
        else if (cmd[ssr_pkg::C_RST] | cmd[ssr_pkg::C_SPRE] | cmd[ssr_pkg::C_CLS])
            armed <= 1'b1;                                       // [R20]
        else if (cmd[ssr_pkg::C_PMT])
            armed <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mav <= 1'b0;
        else if (evt.obuf_load)
            mav <= 1'b1;
        else if (obuf_clr | evt.obuf_drain)
            mav <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            obuf_clear <= 1'b0;
            cmd_flush  <= 1'b0;
        end
        else
        begin
            obuf_clear <= obuf_clr;
            cmd_flush  <= dev_clr;                               // [R18]
        end
    end

    // Status byte summaries
    assign stb_low = {sum[1], 1'b0, |(esr & ese), mav, sum[0], ecnt != 4'h0, 2'b00}; // [R2] [R5]
    assign stb_full = stb_low | {1'b0, |(stb_low & sre), 6'h00};
    assign ist = |(ppe & stb_full);                              // [R8]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            srq <= 1'b0;
        else
            srq <= |(stb_low & sre);                             // [R1] [R22]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            spoll_valid <= 1'b0;
            spoll_byte  <= 8'h00;
        end
        else
        begin
            spoll_valid <= spoll_req;
            spoll_byte  <= spoll_req ? stb_full : spoll_byte;    // [R6]
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pp <= '0;
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                pp.oe[i]   <= ppoll_req & ppc_en & (ppc_line == 3'(i)); // [R7]
                pp.dout[i] <= ppoll_req & ppc_en & (ppc_line == 3'(i)) & (ist ^ ppc_sense); // [R8]
            end
        end
    end

    // Read mux: the binary word is already the weighted decimal value
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        mapped     = 1'b1;
        if (hit(paddr, ssr_pkg::A_CTRL))
            next_rdata = 32'h0000_0000;
        else if (hit(paddr, ssr_pkg::A_CFG))
            next_rdata = {31'h0, psc};
        else if (hit(paddr, ssr_pkg::A_STB))
            next_rdata = {24'h0, stb_full};                      // [R11] [R12] [R13]
        else if (hit(paddr, ssr_pkg::A_ESR))
            next_rdata = {24'h0, esr};
        else if (hit(paddr, ssr_pkg::A_ESE))
            next_rdata = {24'h0, ese};
        else if (hit(paddr, ssr_pkg::A_SRE))
            next_rdata = {24'h0, sre};
        else if (hit(paddr, ssr_pkg::A_PPE))
            next_rdata = {24'h0, ppe};
        else if (hit(paddr, ssr_pkg::A_PPC))
            next_rdata = {27'h0, ppc_en, ppc_sense, ppc_line};
        else if (hit(paddr, ssr_pkg::A_IST))
            next_rdata = {31'h0, ist};                           // [R9]
        else if (hit(paddr, ssr_pkg::A_ERRQ))
            next_rdata = (ecnt != 4'h0) ? {16'h0, errq[rptr]} : 32'h0; // [R14]
        else if (hit(paddr, ssr_pkg::A_SET))
            next_rdata = {16'h0, settings};
        else if (hit(paddr, ssr_pkg::A_ECNT))
            next_rdata = {28'h0, ecnt};
        else
        begin
            mapped = 1'b0;
            for (int g = 0; g < 2; g++)
            begin
                for (int k = 0; k < 5; k++)
                begin
                    if (hit(paddr, ((g == 0) ? ssr_pkg::A_QUES : ssr_pkg::A_OPER) + 8'(4 * k)))
                    begin
                        mapped = 1'b1;
                        unique case (k)
                            0: next_rdata = {16'h0, cond_q[g]};
                            1: next_rdata = {16'h0, ev[g]};      // [R21]
                            2: next_rdata = {16'h0, ena[g]};
                            3: next_rdata = {16'h0, ptr[g]};
                            4: next_rdata = {16'h0, ntr[g]};
                        endcase
                    end
                end
            end
        end
    end

    // Data captured in setup, effects applied at the completing edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata  <= setup ? next_rdata : prdata;
            pready  <= setup;
            pslverr <= setup & ~mapped;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_armed;
        cmd[ssr_pkg::C_CLS] || cmd[ssr_pkg::C_SPRE];
    endsequence
    sequence s_term;
        cmd[ssr_pkg::C_PMT] && !cmd[ssr_pkg::C_CLS] && !cmd[ssr_pkg::C_SPRE] && !cmd[ssr_pkg::C_RST];
    endsequence

    chk_srq_raise: assert property (|(stb_low & sre) |=> srq) // [R1]
        else $error("srq not raised");
    chk_srq_drop: assert property (!(|(stb_low & sre)) |=> !srq) // [R22]
        else $error("srq not withdrawn");
    chk_opc_srq: assert property (evt.opc && ese[0] && sre[5] && !cls_all |-> ##2 srq) // [R4] [R5]
        else $error("opc did not reach srq");
    chk_spoll_byte: assert property (spoll_req |=> spoll_valid && spoll_byte == $past(stb_full)) // [R6]
        else $error("serial poll byte wrong");
    chk_pp_one: assert property ($onehot0(pp.oe)) // [R7]
        else $error("more than one poll line driven");
    chk_pp_value: assert property (ppoll_req && ppc_en |=> pp.dout[$past(ppc_line)] == $past(ist ^ ppc_sense)) // [R8]
        else $error("parallel poll bit wrong");
    chk_bit15_zero: assert property (!ev[0][15] && !ev[1][15] && !cond_q[0][15] && !cond_q[1][15]) // [R21]
        else $error("bit 15 set");
    chk_errq_empty: assert property (setup && hit(paddr, ssr_pkg::A_ERRQ) && ecnt == 4'h0 |=> prdata == 32'h0) // [R14]
        else $error("empty queue not zero");
    chk_errq_pop: assert property (pop && !push && !errq_clr |=> ecnt == $past(ecnt) - 4'h1) // [R14]
        else $error("pop not one entry");
    chk_dcl_keep: assert property (cmd[ssr_pkg::C_DCL] && !por_pend |=> sre == $past(sre) && ese == $past(ese)
                                   && ppe == $past(ppe)
                                   && esr == ($past(esr) | $past(evt.esr_set) | {7'h00, $past(evt.opc)})) // [R15] [R18]
        else $error("device clear touched status");
    chk_preset_fill: assert property (preset |=> ptr[1] == ssr_pkg::PTR_RST && ntr[1] == 16'h0 && ena[1] == 16'h0) // [R16] [R17]
        else $error("status preset incomplete");
    chk_arm_set: assert property (s_armed |=> armed) // [R20]
        else $error("output buffer clear not armed");
    chk_term_clear: assert property (armed && s_term |=> obuf_clear) // [R20]
        else $error("armed output buffer not cleared");
    chk_rst_keep: assert property (cmd[ssr_pkg::C_RST] && !psc_clr |=> sre == $past(sre)) // [R23]
        else $error("reset changed sre");

endmodule // ssr_unit
`default_nettype wire

// ==== test/ssr_ctl_model.sv ====
// Bus controller model: APB master that reaches the status unit registers
`timescale 1ns/1ps
`default_nettype none
module ssr_ctl_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Idle edge first, so a back-to-back call never reassigns psel in one step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // ssr_ctl_model
`default_nettype wire

// ==== test/ssr_unit_test.sv ====
// Self-checking bench of the status and service request unit
`timescale 1ns/1ps
`default_nettype none
module ssr_unit_test;
    logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, rnd = 32'hD050;
    logic e, srq, spoll_req = 1'b0, ppoll_req = 1'b0, spoll_valid, obuf_clear, cmd_flush;
    logic [7:0] spoll_byte;
    logic [15:0] ques_cond_in = 16'h0, oper_cond_in = 16'h0, settings, s;
    ssr_pkg::ssr_evt_s evt = '0, v;
    ssr_pkg::ssr_pp_s pp;
    int miscompares = 0, cmp_count = 0, oc = 0, fc = 0, oc0, fc0;
    int errs[$];

    always #12.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        if (obuf_clear === 1'b1) oc++;
        if (cmd_flush === 1'b1) fc++;
    end

    ssr_ctl_model ctl (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ssr_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .evt(evt), .ques_cond_in(ques_cond_in), .oper_cond_in(oper_cond_in), .spoll_req(spoll_req),
        .ppoll_req(ppoll_req), .srq(srq), .spoll_valid(spoll_valid), .spoll_byte(spoll_byte),
        .pp(pp), .obuf_clear(obuf_clear), .cmd_flush(cmd_flush), .settings(settings));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk_pin(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x)
        begin
            miscompares++;
            $display("Error at %0t: got %0h expected %0h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ctl.xfer(1'b1, a, d, q, e);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] x);
        ctl.xfer(1'b0, a, 32'h0, q, e);
        chk_pin(q, x);
    endtask
    task automatic ev(input ssr_pkg::ssr_evt_s p);
        @(posedge pclk);
        evt <= p;
        @(posedge pclk);
        evt <= '0;
    endtask
    // Bounded wait, then the level itself is the comparison
    task automatic wait_srq(input logic l);
        for (int n = 0; n < 8 && srq !== l; n++) @(posedge pclk);
        chk_pin(srq, l);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #2000000;
        miscompares++;
        test_done;
    end

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk_rd(ssr_pkg::A_CFG, 1);
        chk_rd(ssr_pkg::A_SRE, 0);
        chk_rd(ssr_pkg::A_PPE, 0);
        chk_rd(ssr_pkg::A_QUES + ssr_pkg::R_ENA, 0);
        chk_rd(ssr_pkg::A_OPER + ssr_pkg::R_PTR, ssr_pkg::PTR_RST);
        chk_rd(ssr_pkg::A_OPER + ssr_pkg::R_NTR, 0);
        chk_pin(oc, 1);
        chk_pin(fc, 1);
        $display("test reset done");
        wr(ssr_pkg::A_ESE, 1);
        wr(ssr_pkg::A_SRE, 32);
        v = '0;
        v.opc = 1'b1;
        ev(v);
        wait_srq(1'b1);
        chk_rd(ssr_pkg::A_STB, 8'h60);
        chk_rd(ssr_pkg::A_ESR, 1);
        wait_srq(1'b0);
        $display("test completion done");
        wr(ssr_pkg::A_SRE, 0);
        wr(ssr_pkg::A_QUES + ssr_pkg::R_ENA, 16'h0004);
        ques_cond_in <= 16'h0004;
        oper_cond_in <= rnd[15:0];
        ev(v);
        chk_rd(ssr_pkg::A_STB, 40);
        @(posedge pclk);
        spoll_req <= 1'b1;
        @(posedge pclk);
        spoll_req <= 1'b0;
        #1 chk_pin(spoll_valid, 1);
        chk_pin(spoll_byte, 40);
        chk_rd(ssr_pkg::A_QUES + ssr_pkg::R_EVT, 4);
        chk_rd(ssr_pkg::A_QUES + ssr_pkg::R_EVT, 0);
        chk_rd(ssr_pkg::A_ESR, 1);
        $display("test summary done");
        wr(ssr_pkg::A_SRE, 8'hFF);
        wr(ssr_pkg::A_ESE, 8'hFF);
        for (int i = 0; i < 3; i++)
        begin
            rnd = lfsr(rnd);
            v = '0;
            v.err_push = 1'b1;
            v.err_code = rnd[15:0] | 16'h0001;
            errs.push_back(v.err_code);
            ev(v);
        end
        wait_srq(1'b1);
        while (errs.size() > 0) chk_rd(ssr_pkg::A_ERRQ, errs.pop_front());
        chk_rd(ssr_pkg::A_ERRQ, 0);
        wait_srq(1'b0);
        $display("test error queue done");
        wr(ssr_pkg::A_PPE, 8'h10);
        v = '0;
        v.obuf_load = 1'b1;
        ev(v);
        for (int i = 0; i < 8; i++)
        begin
            wr(ssr_pkg::A_PPC, 32'h10 | i | ((i & 1) << 3));
            @(posedge pclk);
            ppoll_req <= 1'b1;
            repeat (2) @(posedge pclk);
            #1 chk_pin(pp.oe, 32'h1 << i);
            chk_pin(pp.dout[i], 1 ^ (i & 1));
            @(posedge pclk);
            ppoll_req <= 1'b0;
        end
        chk_rd(ssr_pkg::A_IST, 1);
        wr(ssr_pkg::A_PPC, 0);
        ppoll_req <= 1'b1;
        repeat (2) @(posedge pclk);
        #1 chk_pin(pp.oe, 0);
        @(posedge pclk);
        ppoll_req <= 1'b0;
        v = '0;
        v.obuf_drain = 1'b1;
        ev(v);
        chk_rd(ssr_pkg::A_IST, 0);
        $display("test polls done");
        rnd = lfsr(rnd);
        s = rnd[15:0];
        wr(ssr_pkg::A_SET, s);
        oc0 = oc;
        fc0 = fc;
        wr(ssr_pkg::A_CTRL, 1 << ssr_pkg::C_DCL);
        chk_rd(ssr_pkg::A_SET, s);
        chk_pin(oc - oc0, 1);
        chk_pin(fc - fc0, 1);
        chk_rd(ssr_pkg::A_SRE, ssr_pkg::SRE_MASK);
        wr(ssr_pkg::A_CTRL, 1 << ssr_pkg::C_RST);
        chk_rd(ssr_pkg::A_SET, ssr_pkg::SET_RST);
        chk_rd(ssr_pkg::A_SRE, ssr_pkg::SRE_MASK);
        chk_pin(oc - oc0, 1);
        wr(ssr_pkg::A_CTRL, 1 << ssr_pkg::C_PMT);
        repeat (2) @(posedge pclk);
        chk_pin(oc - oc0, 2);
        $display("test clears done");
        wr(ssr_pkg::A_QUES + ssr_pkg::R_ENA, 16'hFFFF);
        chk_rd(ssr_pkg::A_QUES + ssr_pkg::R_ENA, 16'h7FFF);
        wr(ssr_pkg::A_QUES + ssr_pkg::R_PTR, 0);
        wr(ssr_pkg::A_QUES + ssr_pkg::R_NTR, 16'hFFFF);
        v = '0;
        v.esr_set = 8'h80;
        ev(v);
        wr(ssr_pkg::A_CTRL, 1 << ssr_pkg::C_SPRE);
        chk_rd(ssr_pkg::A_QUES + ssr_pkg::R_ENA, 0);
        chk_rd(ssr_pkg::A_QUES + ssr_pkg::R_PTR, ssr_pkg::PTR_RST);
        chk_rd(ssr_pkg::A_QUES + ssr_pkg::R_NTR, 0);
        chk_rd(ssr_pkg::A_ESR, 8'h80);
        v.err_push = 1'b1;
        v.err_code = 16'h0005;
        ev(v);
        wr(ssr_pkg::A_CTRL, 1 << ssr_pkg::C_CLS);
        chk_rd(ssr_pkg::A_ESR, 0);
        chk_rd(ssr_pkg::A_ERRQ, 0);
        wr(ssr_pkg::A_CFG, 0);
        wr(ssr_pkg::A_CTRL, 1 << ssr_pkg::C_PON);
        chk_rd(ssr_pkg::A_SRE, ssr_pkg::SRE_MASK);
        chk_rd(ssr_pkg::A_CFG, 0);
        wr(ssr_pkg::A_CFG, 1);
        wr(ssr_pkg::A_CTRL, 1 << ssr_pkg::C_PON);
        chk_rd(ssr_pkg::A_SRE, 0);
        ctl.xfer(1'b0, 8'hFC, 32'h0, q, e);
        chk_pin(e, 1);
        chk_pin(q, 0);
        $display("test presets done");
        test_done;
    end
endmodule // ssr_unit_test
`default_nettype wire
